// ### fic_float_int_converter.sv
// float/integer conversion datapath, one result per accepted request
// assumes: start, function code and operand words come from logic on clk_sys_i
//
// What this block does
// - code 450 turns the float word pair into a 16-bit signed result word.
// - code 451 turns the float word pair into a 32-bit signed word pair.
// - float to integer keeps the integer part, truncating toward zero.
// - 16-bit conversion flags error when the integer part exceeds signed 16 bits.
// - 32-bit conversion flags error when the integer part exceeds signed 32 bits.
// - not-a-number source flags error; with no range error either, the error flag is cleared.
// - float to integer sets equals when the integer result is zero.
// - float to integer copies the result's top bit into negative.
// - second word holds the upper half, for sources and 32-bit results.
// - code 452 turns a 16-bit signed word into a float word pair.
// - code 453 turns a 32-bit signed word pair into a float word pair.
// - integer to float sets equals only for zero exponent and zero fraction.
// - integer to float sets negative when the float result is negative.
// - magnitudes beyond 24 bits lose precision in the float result.
// - float is sign, 8-bit exponent biased 127, 23-bit fraction, hidden one.
// - not-a-number is all-ones exponent with nonzero fraction.
// - inexact integer-to-float results round to nearest, ties to an even last bit.
`timescale 1ns/10ps
`include "fic_consts.svh"

module fic_float_int_converter (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // request
   input wire logic start_i,
   input wire logic [`FIC_FN_W-1:0] func_code_i,
   input wire logic [15:0] src_lo_i,
   input wire logic [15:0] src_hi_i,
   // result words
   output logic [15:0] res_lo_o,
   output logic [15:0] res_hi_o,
   // condition flags
   output logic error_flag_o,
   output logic equals_flag_o,
   output logic negative_flag_o,
   // completion
   output logic done_o
);

   // ---------------- request decode ----------------
   wire logic hit_f2i16;
   wire logic hit_f2i32;
   wire logic hit_i162f;
   wire logic hit_i322f;
   wire logic code_ok;
   fic_pkg::fic_op_t op;

   assign hit_f2i16 = (func_code_i == `FIC_FN_F2I16);
   assign hit_f2i32 = (func_code_i == `FIC_FN_F2I32);
   assign hit_i162f = (func_code_i == `FIC_FN_I162F);
   assign hit_i322f = (func_code_i == `FIC_FN_I322F);
   assign code_ok = hit_f2i16 | hit_f2i32 | hit_i162f | hit_i322f;
   assign op = hit_f2i32 ? fic_pkg::FIC_OP_F2I32 :
               hit_i162f ? fic_pkg::FIC_OP_I162F :
               hit_i322f ? fic_pkg::FIC_OP_I322F :
                           fic_pkg::FIC_OP_F2I16;

   // the second source word is the upper half
   wire logic [31:0] src_pair;
   assign src_pair = {src_hi_i, src_lo_i};

   // ---------------- float source fields ----------------
   wire logic f_sign;
   wire logic [7:0] f_exp;
   wire logic [22:0] f_frac;
   wire logic [23:0] f_mant;
   wire logic f_nan;
   wire logic f_below_one;

   assign f_sign = src_pair[`FIC_SIGN_BIT];
   assign f_exp = src_pair[`FIC_EXP_HI:`FIC_EXP_LO];
   assign f_frac = src_pair[`FIC_FRAC_HI:`FIC_FRAC_LO];
   assign f_mant = {1'b1, f_frac};
   assign f_nan = (f_exp == `FIC_EXP_ONES) && (f_frac != 23'h000000);
   // zeros, denormals and anything under one truncate to zero
   assign f_below_one = (f_exp < `FIC_EXP_BIAS);

   // ---------------- float to integer magnitude ----------------
   // exponents above the 32-bit limit, and at it except for -2^31, are handled as range errors,
   // so the left shift never needs more than eight places
   wire logic shift_up;
   wire logic [7:0] up_amt;
   wire logic [7:0] dn_amt;
   wire logic [31:0] mag_up;
   wire logic [31:0] mag_dn;
   wire logic [31:0] f_mag;

   assign shift_up = (f_exp >= `FIC_EXP_UNIT);
   assign up_amt = 8'(f_exp - `FIC_EXP_UNIT);
   assign dn_amt = 8'(`FIC_EXP_UNIT - f_exp);
   assign mag_up = {8'h00, f_mant} << up_amt[3:0];
   // bits shifted out on the right are the fraction, simply dropped
   assign mag_dn = {8'h00, f_mant} >> dn_amt[4:0];
   assign f_mag = f_below_one ? 32'h0000_0000 :
                  shift_up ? mag_up : mag_dn;

   // ---------------- range checks ----------------
   // the negative limits are one step wider than the positive ones
   wire logic big32;
   wire logic neg_lim32;
   wire logic over32;
   wire logic over16;

   assign big32 = (f_exp >= `FIC_EXP_LIM32);
   assign neg_lim32 = f_sign && (f_exp == `FIC_EXP_LIM32) && (f_frac == 23'h000000);
   assign over32 = big32 && !neg_lim32;
   assign over16 = big32 ||
                   ((f_mag > `FIC_MAG16_MAX) &&
                    !(f_sign && (f_mag == `FIC_MAG16_MIN)));

   // ---------------- signed integer results ----------------
   wire logic [31:0] int32_val;
   wire logic [15:0] int16_val;
   wire logic err16;
   wire logic err32;

   assign int32_val = f_sign ? 32'(-f_mag) : f_mag;
   assign int16_val = int32_val[15:0];
   assign err16 = f_nan || over16;
   assign err32 = f_nan || over32;

   // ---------------- integer source ----------------
   // a 16-bit source is sign-extended so both widths share one path
   wire logic [31:0] i_val;
   wire logic i_sign;
   wire logic [31:0] i_mag;
   wire logic i_zero;

   assign i_val = (op == fic_pkg::FIC_OP_I162F) ?
                  {{16{src_lo_i[15]}}, src_lo_i} :
                  src_pair;
   assign i_sign = i_val[31];
   // the most negative input has magnitude 2^31, still fits unsigned
   assign i_mag = i_sign ? 32'(-i_val) : i_val;
   assign i_zero = (i_mag == 32'h0000_0000);

   // ---------------- leading one search ----------------
   logic [4:0] msb_pos;

   always_comb begin
      msb_pos = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (i_mag[i]) begin
            msb_pos = 5'(i);
         end
      end
   end

   // ---------------- normalise and round ----------------
   wire logic [4:0] norm_amt;
   wire logic [31:0] i_norm;
   wire logic rnd_guard;
   wire logic rnd_sticky;
   wire logic rnd_lsb;
   wire logic rnd_up;
   wire logic [24:0] mant_sum;
   wire logic mant_carry;
   wire logic [22:0] r_frac;
   wire logic [7:0] r_exp;
   wire logic [31:0] r_float;

   assign norm_amt = `FIC_TOP_POS - msb_pos;
   assign i_norm = i_mag << norm_amt;
   // only 24 significant bits survive; the rest decide the rounding
   assign rnd_guard = i_norm[`FIC_RND_BIT];
   assign rnd_sticky = |i_norm[`FIC_RND_BIT-1:0];
   assign rnd_lsb = i_norm[`FIC_RND_BIT+1];
   assign rnd_up = rnd_guard && (rnd_sticky || rnd_lsb);
   assign mant_sum = {1'b0, i_norm[31:8]} + {24'h000000, rnd_up};
   assign mant_carry = mant_sum[24];
   // a carry out leaves an all-zero fraction one exponent higher
   assign r_frac = mant_carry ? 23'h000000 : mant_sum[22:0];
   assign r_exp = i_zero ? `FIC_EXP_ZERO :
                  8'(`FIC_EXP_BIAS + {3'h0, msb_pos} + {7'h00, mant_carry});
   assign r_float = {i_sign, r_exp, r_frac};

   // ---------------- per-operation next values ----------------
   logic [15:0] res_lo_ff;
   logic [15:0] res_hi_ff;
   logic err_ff;
   logic eq_ff;
   logic neg_ff;
   logic done_ff;
   logic [15:0] nxt_res_lo;
   logic [15:0] nxt_res_hi;
   logic nxt_err;
   logic nxt_eq;
   logic nxt_neg;

   // a failed float-to-integer request leaves the result words untouched
   always_comb begin
      nxt_res_lo = res_lo_ff;
      nxt_res_hi = res_hi_ff;
      nxt_err = `FIC_FLAG_RST;
      nxt_eq = `FIC_FLAG_RST;
      nxt_neg = `FIC_FLAG_RST;
      case (op)
         fic_pkg::FIC_OP_F2I16: begin
            nxt_err = err16;
            if (!err16) begin
               nxt_res_lo = int16_val;
               nxt_eq = (int16_val == 16'h0000);
               nxt_neg = int16_val[15];
            end
         end
         fic_pkg::FIC_OP_F2I32: begin
            nxt_err = err32;
            if (!err32) begin
               nxt_res_lo = int32_val[15:0];
               nxt_res_hi = int32_val[31:16];
               nxt_eq = (int32_val == 32'h0000_0000);
               nxt_neg = int32_val[31];
            end
         end
         fic_pkg::FIC_OP_I162F, fic_pkg::FIC_OP_I322F: begin
            nxt_err = `FIC_FLAG_RST;
            nxt_res_lo = r_float[15:0];
            nxt_res_hi = r_float[31:16];
            nxt_eq = (r_exp == `FIC_EXP_ZERO) && (r_frac == 23'h000000);
            nxt_neg = r_float[`FIC_SIGN_BIT];
         end
         default: begin
            nxt_err = `FIC_FLAG_RST;
         end
      endcase
   end

   // ---------------- result registers ----------------
   wire logic take;

   // unknown function codes are ignored: no done, nothing changes
   assign take = start_i && code_ok;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         res_lo_ff <= `FIC_WORD_RST;
         res_hi_ff <= `FIC_WORD_RST;
         err_ff <= `FIC_FLAG_RST;
         eq_ff <= `FIC_FLAG_RST;
         neg_ff <= `FIC_FLAG_RST;
         done_ff <= `FIC_FLAG_RST;
      end else begin
         done_ff <= take;
         if (take) begin
            res_lo_ff <= nxt_res_lo;
            res_hi_ff <= nxt_res_hi;
            err_ff <= nxt_err;
            eq_ff <= nxt_eq;
            neg_ff <= nxt_neg;
         end
      end
   end

   assign res_lo_o = res_lo_ff;
   assign res_hi_o = res_hi_ff;
   assign error_flag_o = err_ff;
   assign equals_flag_o = eq_ff;
   assign negative_flag_o = neg_ff;
   assign done_o = done_ff;

endmodule

// ### fic_consts.svh
// constants of the float/integer conversion datapath
// assumes: included by its bare name wherever a number is needed
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH

// function codes 450..453
`define FIC_FN_W 9
`define FIC_FN_F2I16 9'h1c2
`define FIC_FN_F2I32 9'h1c3
`define FIC_FN_I162F 9'h1c4
`define FIC_FN_I322F 9'h1c5

// single-precision field layout
`define FIC_SIGN_BIT 31
`define FIC_EXP_HI 30
`define FIC_EXP_LO 23
`define FIC_FRAC_HI 22
`define FIC_FRAC_LO 0

// exponent values
`define FIC_EXP_ZERO 8'h00
`define FIC_EXP_ONES 8'hff
`define FIC_EXP_BIAS 8'h7f
`define FIC_EXP_UNIT 8'h96
`define FIC_EXP_LIM16 8'h8e
`define FIC_EXP_LIM32 8'h9e

// integer limits as magnitudes
`define FIC_MAG16_MAX 32'h0000_7fff
`define FIC_MAG16_MIN 32'h0000_8000

// normalisation
`define FIC_TOP_POS 5'h1f
`define FIC_RND_BIT 7

// reset values
`define FIC_WORD_RST 16'h0000
`define FIC_FLAG_RST 1'b0

`endif

// ### fic_pkg.sv
// types of the float/integer conversion datapath
// assumes: fic_consts.svh holds the numbers
package fic_pkg;

   typedef enum logic [1:0] {
      FIC_OP_F2I16 = 2'b00,
      FIC_OP_F2I32 = 2'b01,
      FIC_OP_I162F = 2'b10,
      FIC_OP_I322F = 2'b11
   } fic_op_t;

endpackage

// ### fic_float_int_converter_props.sv
// checker of the float/integer converter, sees only its ports
// assumes: single clock domain, async active-low reset
`timescale 1ns/10ps
`include "fic_consts.svh"
module fic_float_int_converter_props (
   input wire logic clk_sys_i, arst_n_i, start_i,
   input wire logic [`FIC_FN_W-1:0] func_code_i,
   input wire logic [15:0] src_lo_i, src_hi_i, res_lo_o, res_hi_o,
   input wire logic error_flag_o, equals_flag_o, negative_flag_o, done_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   wire f2i = (func_code_i == `FIC_FN_F2I16) || (func_code_i == `FIC_FN_F2I32);
   wire i2f = (func_code_i == `FIC_FN_I162F) || (func_code_i == `FIC_FN_I322F);
   wire src_nan = (src_hi_i[14:7] == `FIC_EXP_ONES) && ({src_hi_i[6:0], src_lo_i} != 23'h0);
   sequence s_take; start_i && (f2i || i2f); endsequence
   sequence s_take_i2f; start_i && i2f; endsequence
   sequence s_done_f2i(logic [`FIC_FN_W-1:0] code); done_o && ($past(func_code_i) == code) && !error_flag_o;
   endsequence
   property p_done; s_take |=> done_o; endproperty
   a_done: assert property (p_done) else $error("no done after accepted request");
   property p_i2f_err; s_take_i2f |=> !error_flag_o; endproperty
   a_i2f_err: assert property (p_i2f_err) else $error("error flag set by int to float");
   property p_i2f_eq; s_take_i2f |=> equals_flag_o == ({res_hi_o[14:0], res_lo_o} == 31'h0); endproperty
   a_i2f_eq: assert property (p_i2f_eq) else $error("equals flag wrong for int to float");
   property p_i2f_neg; s_take_i2f |=> negative_flag_o == res_hi_o[15]; endproperty
   a_i2f_neg: assert property (p_i2f_neg) else $error("negative flag wrong for int to float");
   property p_hi_keep; start_i && (func_code_i == `FIC_FN_F2I16) |=> $stable(res_hi_o); endproperty
   a_hi_keep: assert property (p_hi_keep) else $error("upper result word changed by 16-bit op");
   property p_nan; start_i && f2i && src_nan |=> error_flag_o; endproperty
   a_nan: assert property (p_nan) else $error("not-a-number source without error");
   property p_eq16; s_done_f2i(`FIC_FN_F2I16) |-> equals_flag_o == (res_lo_o == 16'h0000); endproperty
   a_eq16: assert property (p_eq16) else $error("equals flag wrong for 16-bit result");
   property p_neg32; s_done_f2i(`FIC_FN_F2I32) |-> negative_flag_o == res_hi_o[15]; endproperty
   a_neg32: assert property (p_neg32) else $error("negative flag wrong for 32-bit result");
   property p_small; start_i && f2i && (src_hi_i[14:7] < `FIC_EXP_BIAS) |=> !error_flag_o && equals_flag_o;
   endproperty
   a_small: assert property (p_small) else $error("magnitude below one not zero");
endmodule
bind fic_float_int_converter fic_float_int_converter_props u_fic_float_int_converter_props (.clk_sys_i(clk_sys_i),
   .arst_n_i(arst_n_i), .start_i(start_i), .func_code_i(func_code_i), .src_lo_i(src_lo_i), .src_hi_i(src_hi_i),
   .res_lo_o(res_lo_o), .res_hi_o(res_hi_o), .error_flag_o(error_flag_o), .equals_flag_o(equals_flag_o),
   .negative_flag_o(negative_flag_o), .done_o(done_o));

// ### fic_seq_model.sv
// instruction sequencer model feeding operand words to the converter
// assumes: changes its outputs on the falling edge only
`timescale 1ns/10ps
`include "fic_consts.svh"
module fic_seq_model (
   input wire logic clk_sys_i,
   output logic start_o,
   output logic [`FIC_FN_W-1:0] func_code_o,
   output logic [15:0] src_lo_o,
   output logic [15:0] src_hi_o
);
   initial begin
      start_o = 1'b0;
      func_code_o = '0;
      src_lo_o = 16'h0000;
      src_hi_o = 16'h0000;
   end
   // one-cycle request; words turn to garbage afterwards so late sampling shows up
   task automatic issue(input logic [`FIC_FN_W-1:0] code, input logic [31:0] src);
      @(negedge clk_sys_i);
      start_o = 1'b1;
      func_code_o = code;
      {src_hi_o, src_lo_o} = src;
      @(negedge clk_sys_i);
      start_o = 1'b0;
      {src_hi_o, src_lo_o} = ~src;
   endtask
endmodule

// ### fic_float_int_converter_bench.sv
// self-checking bench of the float/integer converter
// assumes: sequencer model drives requests, bench samples on falling edges
`timescale 1ns/10ps
`include "fic_consts.svh"
module fic_float_int_converter_bench;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic start_i;
   logic [`FIC_FN_W-1:0] func_code_i;
   logic [15:0] src_lo_i, src_hi_i, res_lo_o, res_hi_o;
   logic error_flag_o, equals_flag_o, negative_flag_o, done_o;
   logic [31:0] exp_res = 32'h0;
   int fails = 0;
   int num_checks = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   fic_seq_model u_fic_seq_model (.clk_sys_i(clk_sys_i), .start_o(start_i), .func_code_o(func_code_i),
      .src_lo_o(src_lo_i), .src_hi_o(src_hi_i));
   fic_float_int_converter u_fic_float_int_converter (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .start_i(start_i), .func_code_i(func_code_i), .src_lo_i(src_lo_i), .src_hi_i(src_hi_i),
      .res_lo_o(res_lo_o), .res_hi_o(res_hi_o), .error_flag_o(error_flag_o), .equals_flag_o(equals_flag_o),
      .negative_flag_o(negative_flag_o), .done_o(done_o));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // wr: bit0 writes the lower word, bit1 the upper; unwritten words must hold
   task automatic run(input logic [`FIC_FN_W-1:0] code, input logic [31:0] src, input logic [1:0] wr,
      input logic [31:0] res, input logic [2:0] flags);
      u_fic_seq_model.issue(code, src);
      if (wr[0]) exp_res[15:0] = res[15:0];
      if (wr[1]) exp_res[31:16] = res[31:16];
      check("done", done_o, 32'(wr != 2'b00 || flags != 3'b000));
      check("result", {res_hi_o, res_lo_o}, exp_res);
      check("flags", {error_flag_o, equals_flag_o, negative_flag_o}, flags);
   endtask
   task automatic t_f2i16;
      run(`FIC_FN_F2I16, 32'h4060_0000, 2'b01, 32'h0000_0003, 3'b000);
      run(`FIC_FN_F2I16, 32'hc060_0000, 2'b01, 32'h0000_fffd, 3'b001);
      run(`FIC_FN_F2I16, 32'h46ff_fe00, 2'b01, 32'h0000_7fff, 3'b000);
      run(`FIC_FN_F2I16, 32'hc700_0000, 2'b01, 32'h0000_8000, 3'b001);
      run(`FIC_FN_F2I16, 32'h4700_0000, 2'b00, 32'h0, 3'b100);
      run(`FIC_FN_F2I16, 32'hbf00_0000, 2'b01, 32'h0, 3'b010);
      run(`FIC_FN_F2I16, 32'h7fc0_0000, 2'b00, 32'h0, 3'b100);
   endtask
   task automatic t_f2i32;
      run(`FIC_FN_F2I32, 32'h47c3_5040, 2'b11, 32'h0001_86a0, 3'b000);
      run(`FIC_FN_F2I32, 32'hcf00_0000, 2'b11, 32'h8000_0000, 3'b001);
      run(`FIC_FN_F2I32, 32'h4f00_0000, 2'b00, 32'h0, 3'b100);
      run(`FIC_FN_F2I32, 32'h8000_0000, 2'b11, 32'h0, 3'b010);
      run(`FIC_FN_F2I32, 32'hffc0_0001, 2'b00, 32'h0, 3'b100);
      run(`FIC_FN_F2I32, 32'h7f80_0000, 2'b00, 32'h0, 3'b100);
   endtask
   task automatic t_i2f;
      run(`FIC_FN_I162F, 32'hffff_0003, 2'b11, 32'h4040_0000, 3'b000);
      run(`FIC_FN_I162F, 32'h0000_fffd, 2'b11, 32'hc040_0000, 3'b001);
      run(`FIC_FN_I162F, 32'h1234_8000, 2'b11, 32'hc700_0000, 3'b001);
      run(`FIC_FN_I162F, 32'hffff_0000, 2'b11, 32'h0000_0000, 3'b010);
      run(`FIC_FN_I322F, 32'h00ff_ffff, 2'b11, 32'h4b7f_ffff, 3'b000);
      run(`FIC_FN_I322F, 32'hff00_0001, 2'b11, 32'hcb7f_ffff, 3'b001);
      run(`FIC_FN_I322F, 32'h0100_0001, 2'b11, 32'h4b80_0000, 3'b000);
      run(`FIC_FN_I322F, 32'h0100_0003, 2'b11, 32'h4b80_0002, 3'b000);
      run(`FIC_FN_I322F, 32'h7fff_ffff, 2'b11, 32'h4f00_0000, 3'b000);
   endtask
   // unsupported code: no completion and every output holds
   task automatic t_refused;
      run(9'h1c6, 32'h4060_0000, 2'b00, 32'h0, 3'b000);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      t_f2i16();
      t_f2i32();
      t_i2f();
      t_refused();
      end_of_test();
   end
   // about 46 request cycles plus reset; far more than that means a hang
   initial begin
      #(25 * 2000);
      fails++;
      end_of_test();
   end
endmodule
